// *** design/lac_loop_ctrl.v ***
// Loopback routing, all-ones generator and jitter attenuator for one line
// interface channel, with an APB register slave.
// Assumes line and system pins arrive asynchronously and are sampled on
// core_clk, which runs at least twice the fastest bit clock.
`timescale 1ns/1ps
`include "lac_loop_regs.vh"

module lac_loop_ctrl #(
	parameter JA_DEPTH = 128,
	parameter AW       = 7
) (
	// Clock, reset and clock enable
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        ce,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// Hardware-mode control pins
	input  wire        host_mode,
	input  wire        local_loop_select,
	input  wire        remote_loop_select,
	input  wire        send_all_ones,
	// System transmit side
	input  wire        system_tx_clock,
	input  wire        tx_pos_data_in,
	input  wire        tx_neg_data_in,
	// Line receive side, after clock and data recovery
	input  wire        recovered_rx_clock,
	input  wire        line_rx_pos,
	input  wire        line_rx_neg,
	// Line transmit side
	output reg         tx_timing_clock,
	output reg         line_tx_pos,
	output reg         line_tx_neg,
	// System receive side
	output reg         rx_clock_out,
	output reg         rx_pos_data_out,
	output reg         rx_neg_data_out
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	reg  [9:0] sync1;
	reg  [9:0] sync2;
	reg        sys_clk_d;
	reg        rx_clk_d;
	wire [9:0] pins;

	assign pins = {host_mode, local_loop_select, remote_loop_select,
		send_all_ones, system_tx_clock, tx_pos_data_in, tx_neg_data_in,
		recovered_rx_clock, line_rx_pos, line_rx_neg};

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1     <= 10'h000;
			sync2     <= 10'h000;
			sys_clk_d <= 1'b0;
			rx_clk_d  <= 1'b0;
		end else if (ce) begin
			sync1     <= pins;
			sync2     <= sync1;
			sys_clk_d <= sync2[5];
			rx_clk_d  <= sync2[2];
		end
	end

	wire sys_stb = sync2[5] & ~sys_clk_d;
	wire sys_pos = sync2[4];
	wire sys_neg = sync2[3];
	wire lrx_stb = sync2[2] & ~rx_clk_d;
	wire lrx_pos = sync2[1];
	wire lrx_neg = sync2[0];

	// ****************************************************************
	// APB registers
	// ****************************************************************
	reg  [6:0] ctrl;
	wire       acc      = psel & penable & ce;
	wire       hit_ctrl = (paddr == `LAC_CTRL_OFS);
	wire       hit_stat = (paddr == `LAC_STAT_OFS);

	// Holding pready low while frozen keeps the master waiting.
	assign pready  = ce;
	assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `LAC_CTRL_RST;
		end else if (acc && pwrite && hit_ctrl) begin
			ctrl <= pwdata[6:0];
		end
	end

	// ****************************************************************
	// Mode selection
	// ****************************************************************
	wire       in_host = sync2[9];
	wire       sel_loc = in_host ? ctrl[`LAC_CTRL_LOCAL]  : sync2[8];
	wire       sel_rem = in_host ? ctrl[`LAC_CTRL_REMOTE] : sync2[7];
	wire       aos     = in_host ? ctrl[`LAC_CTRL_AOS]    : sync2[6];
	wire       m_ana   = sel_loc & ~sel_rem;
	wire       m_dig   = sel_loc & sel_rem;
	wire       m_rem   = ~sel_loc & sel_rem;
	wire       m_nrm   = ~sel_loc & ~sel_rem;
	wire [1:0] ja_size = ctrl[`LAC_CTRL_SIZE_HI:`LAC_CTRL_SIZE_LO];
	wire       ja_on   = (ja_size != `LAC_SIZE_OFF);
	wire       ja_tx   = ja_on & ctrl[`LAC_CTRL_JA_TX];
	wire       ja_rx   = ja_on & ~ctrl[`LAC_CTRL_JA_TX];
	wire       desync  = ctrl[`LAC_CTRL_DESYNC];

	localparam [AW:0] LIM_16 = 16, LIM_32 = 32, LIM_MAX = JA_DEPTH;
	function [AW:0] lac_limit;
		input [1:0] size;
		begin
			case (size)
				`LAC_SIZE_16:  lac_limit = LIM_16;
				`LAC_SIZE_32:  lac_limit = LIM_32;
				default:       lac_limit = LIM_MAX;
			endcase
		end
	endfunction

	function [AW-1:0] lac_next;
		input [AW-1:0] ptr;
		input [AW:0]   lim;
		begin
			lac_next = ({1'b0, ptr} == lim - 1'b1) ? {AW{1'b0}}
				: ptr + 1'b1;
		end
	endfunction

	// ****************************************************************
	// Stream routing
	// ****************************************************************
	// A stream is a one-cycle bit strobe with a positive and negative rail.
	reg  ja_o_stb, ja_o_pos, ja_o_neg;
	reg  rxi_stb, rxi_pos, rxi_neg;
	reg  rxp_stb, rxp_pos, rxp_neg;
	reg  txp_stb, txp_pos, txp_neg;
	reg  txq_stb, txq_pos, txq_neg;
	reg  jai_stb, jai_pos, jai_neg;

	always @* begin
		// Receiver input: in analog loop the registered line drive is looped.
		if (m_ana) begin
			rxi_stb = tx_timing_clock;
			rxi_pos = line_tx_pos;
			rxi_neg = line_tx_neg;
		end else begin
			rxi_stb = lrx_stb & ~m_dig;
			rxi_pos = lrx_pos;
			rxi_neg = lrx_neg;
		end
		// Receive side after the attenuator when it sits there.
		if (ja_rx) begin
			rxp_stb = ja_o_stb;
			rxp_pos = ja_o_pos;
			rxp_neg = ja_o_neg;
		end else begin
			rxp_stb = rxi_stb;
			rxp_pos = rxi_pos;
			rxp_neg = rxi_neg;
		end
		// Transmit source before the attenuator.
		if (m_rem) begin
			txp_stb = rxp_stb;
			txp_pos = rxp_pos;
			txp_neg = rxp_neg;
		end else begin
			txp_stb = sys_stb;
			txp_pos = sys_pos;
			txp_neg = sys_neg;
		end
		// Attenuator input follows the selected path.
		if (ja_tx) begin
			jai_stb = txp_stb;
			jai_pos = txp_pos;
			jai_neg = txp_neg;
		end else begin
			jai_stb = rxi_stb;
			jai_pos = rxi_pos;
			jai_neg = rxi_neg;
		end
		// Transmit side after the attenuator when it sits there.
		if (ja_tx) begin
			txq_stb = ja_o_stb;
			txq_pos = ja_o_pos;
			txq_neg = ja_o_neg;
		end else begin
			txq_stb = txp_stb;
			txq_pos = txp_pos;
			txq_neg = txp_neg;
		end
	end

	// ****************************************************************
	// Jitter attenuator
	// ****************************************************************
	// An elastic store read at an adaptive pace. In de-sync mode the pace
	// moves only once every few bits, so gaps and pointer bursts are spread
	// out instead of passed on, at the price of slower tracking.
	reg  [1:0]    mem [0:JA_DEPTH-1];
	reg  [AW-1:0] wptr;
	reg  [AW-1:0] rptr;
	reg  [AW:0]   fill;
	reg           primed;
	reg  [3:0]    pace, pace_cnt, step_cnt;
	wire [AW:0]   limit = lac_limit(ja_size);
	wire          wr    = jai_stb & ja_on & (fill < limit);
	wire          rd    = primed & (pace_cnt == 4'h0)
		& (fill != {(AW+1){1'b0}});
	wire          adj   = ~desync | (step_cnt == 4'h0);

	always @(posedge core_clk) begin
		if (ce && wr) begin
			mem[wptr] <= {jai_pos, jai_neg};
		end
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wptr     <= {AW{1'b0}};
			rptr     <= {AW{1'b0}};
			fill     <= {(AW+1){1'b0}};
			primed   <= 1'b0;
			pace     <= `LAC_PACE_INIT;
			pace_cnt <= 4'h0;
			step_cnt <= 4'h0;
			ja_o_stb <= 1'b0;
			ja_o_pos <= 1'b0;
			ja_o_neg <= 1'b0;
		end else if (ce) begin
			ja_o_stb <= rd;
			if (wr) begin
				wptr <= lac_next(wptr, limit);
			end
			if (rd) begin
				ja_o_pos <= mem[rptr][1];
				ja_o_neg <= mem[rptr][0];
				rptr     <= lac_next(rptr, limit);
			end
			fill <= fill + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
			if (!ja_on) begin
				primed <= 1'b0;
			end else if (fill >= (limit >> 1)) begin
				primed <= 1'b1;
			end else if (fill == {(AW+1){1'b0}}) begin
				primed <= 1'b0;
			end
			if (rd || pace_cnt != 4'h0 || !primed) begin
				pace_cnt <= rd ? pace - 1'b1 : (primed ? pace_cnt - 1'b1
					: 4'h0);
			end
			if (rd) begin
				step_cnt <= (step_cnt == 4'h0) ? `LAC_DESYNC_STEP
					: step_cnt - 1'b1;
				if (adj && fill > (limit >> 1) && pace > `LAC_PACE_MIN) begin
					pace <= pace - 1'b1;
				end else if (adj && fill < (limit >> 2)
					&& pace < `LAC_PACE_MAX) begin
					pace <= pace + 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Line transmit and all-ones generator
	// ****************************************************************
	reg aos_phase;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_timing_clock <= 1'b0;
			line_tx_pos     <= 1'b0;
			line_tx_neg     <= 1'b0;
			aos_phase       <= 1'b0;
		end else if (ce) begin
			if (m_dig) begin
				tx_timing_clock <= 1'b0;
				line_tx_pos     <= 1'b0;
				line_tx_neg     <= 1'b0;
			end else if (aos) begin
				tx_timing_clock <= sys_stb;
				if (sys_stb) begin
					line_tx_pos <= ~aos_phase;
					line_tx_neg <= aos_phase;
					aos_phase   <= ~aos_phase;
				end
			end else begin
				tx_timing_clock <= txq_stb;
				if (txq_stb) begin
					line_tx_pos <= txq_pos;
					line_tx_neg <= txq_neg;
				end
			end
		end
	end

	// ****************************************************************
	// System receive outputs
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_clock_out    <= 1'b0;
			rx_pos_data_out <= 1'b0;
			rx_neg_data_out <= 1'b0;
		end else if (ce) begin
			if (m_dig) begin
				rx_clock_out <= sys_stb;
				if (sys_stb) begin
					rx_pos_data_out <= sys_pos;
					rx_neg_data_out <= sys_neg;
				end
			end else begin
				rx_clock_out <= rxp_stb;
				if (rxp_stb) begin
					rx_pos_data_out <= rxp_pos;
					rx_neg_data_out <= rxp_neg;
				end
			end
		end
	end

	// ****************************************************************
	// APB read data
	// ****************************************************************
	// The attenuator keeps all sizes, both paths and the extra de-sync mode.
	wire [31:0] stat = {18'h00000, primed, fill, aos,
		m_rem, m_dig, m_ana, m_nrm};

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata <= hit_ctrl ? {25'h0000000, ctrl} :
				(hit_stat ? stat : 32'h00000000);
		end
	end

endmodule // lac_loop_ctrl

// *** design/lac_loop_regs.vh ***
// Register offsets, field positions, reset values and pacing counts for the
// loopback and all-ones control block.
// Assumes inclusion by the block's single design file.
`ifndef LAC_LOOP_REGS_VH
`define LAC_LOOP_REGS_VH

// Byte addresses of the APB registers.
`define LAC_CTRL_OFS      12'h000
`define LAC_STAT_OFS      12'h004

// Channel control register fields.
`define LAC_CTRL_LOCAL    0
`define LAC_CTRL_REMOTE   1
`define LAC_CTRL_AOS      2
`define LAC_CTRL_SIZE_LO  3
`define LAC_CTRL_SIZE_HI  4
`define LAC_CTRL_JA_TX    5
`define LAC_CTRL_DESYNC   6
`define LAC_CTRL_RST      7'h18

// Status register fields.
`define LAC_STAT_MODE_LO  0
`define LAC_STAT_MODE_HI  3
`define LAC_STAT_AOS      4
`define LAC_STAT_FILL_LO  5
`define LAC_STAT_FILL_HI  12
`define LAC_STAT_PRIMED   13

// Jitter attenuator sizes selected by the two-bit size field.
`define LAC_SIZE_16       2'h0
`define LAC_SIZE_32       2'h1
`define LAC_SIZE_128      2'h2
`define LAC_SIZE_OFF      2'h3

// Read pacing in core clock cycles per output bit, and the de-sync step count in output bits.
`define LAC_PACE_INIT     4'h2
`define LAC_PACE_MIN      4'h1
`define LAC_PACE_MAX      4'hF
`define LAC_DESYNC_STEP   4'hF

`endif

// *** dv/lac_loop_props.sv ***
// Concurrent checks on the ports of the loopback and all-ones block.
// Assumes pin-mode selects stay steady while bit streams run.
`timescale 1ns/1ps
module lac_loop_props #(
	parameter JA_DEPTH = 128,
	parameter AW       = 7
) (
	// Clock, reset and APB
	input wire        core_clk,
	input wire        rstn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire        pready,
	input wire        pslverr,
	// Pins and streams
	input wire        host_mode,
	input wire        local_loop_select,
	input wire        remote_loop_select,
	input wire        send_all_ones,
	input wire        system_tx_clock,
	input wire        recovered_rx_clock,
	input wire        tx_timing_clock,
	input wire        line_tx_pos,
	input wire        line_tx_neg,
	input wire        rx_clock_out
);
	wire dig = !host_mode && local_loop_select && remote_loop_select;
	wire ana = !host_mode && local_loop_select && !remote_loop_select;
	wire rem = !host_mode && remote_loop_select && !local_loop_select;
	wire aos = !host_mode && send_all_ones && !dig;
	logic [3:0] st;
	logic       last_pos;
	logic       seen;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Marks count only once all-ones has settled past the pin synchroniser.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st       <= 4'h0;
			last_pos <= 1'b0;
			seen     <= 1'b0;
		end else if (!aos) begin
			st   <= 4'h0;
			seen <= 1'b0;
		end else begin
			st <= (st == 4'h8) ? st : st + 4'h1;
			if (tx_timing_clock && st == 4'h8) begin
				last_pos <= line_tx_pos;
				seen     <= 1'b1;
			end
		end
	end

	a_ready_follows_ce: assert property (pready == ce)
		else $error("pready differs from ce");
	a_bad_addr_err: assert property (psel && penable |->
		pslverr == (paddr != 12'h000 && paddr != 12'h004))
		else $error("pslverr wrong for address");
	a_dig_to_rx: assert property (
		dig [*8] ##0 $rose(system_tx_clock) |-> ##[2:6] rx_clock_out)
		else $error("digital loop lost a bit");
	a_dig_line_quiet: assert property (
		dig [*8] |-> !tx_timing_clock && !line_tx_pos && !line_tx_neg)
		else $error("line driven in digital loop");
	a_dig_rx_ignored: assert property (
		(dig && !system_tx_clock) [*8] |-> !rx_clock_out)
		else $error("receive output without system clock");
	a_ana_rx_ignored: assert property (
		(ana && !system_tx_clock) [*8] |-> !rx_clock_out)
		else $error("analog loop passed line input");
	a_rem_to_line: assert property (
		(rem && !send_all_ones) [*8] ##0 $rose(recovered_rx_clock)
		|-> ##[2:6] tx_timing_clock)
		else $error("remote loop lost a bit");
	a_rem_sys_ignored: assert property (
		(rem && !send_all_ones && !recovered_rx_clock) [*8]
		|-> !tx_timing_clock)
		else $error("system clock reached line in remote loop");
	a_aos_pace: assert property (
		aos [*8] ##0 $rose(system_tx_clock) |-> ##[2:6] tx_timing_clock)
		else $error("all-ones mark missing");
	a_aos_one_mark: assert property (
		st == 4'h8 && tx_timing_clock |-> line_tx_pos != line_tx_neg)
		else $error("all-ones mark not on one rail");
	a_aos_alternate: assert property (
		st == 4'h8 && seen && tx_timing_clock |-> line_tx_pos != last_pos)
		else $error("all-ones marks do not alternate");

	c_dig: cover property (dig [*8] ##0 rx_clock_out);
	c_aos: cover property (st == 4'h8 && seen && tx_timing_clock);
	c_err: cover property (psel && penable && pslverr);
endmodule // lac_loop_props

bind lac_loop_ctrl lac_loop_props #(.JA_DEPTH(JA_DEPTH), .AW(AW)) u_props (
	.core_clk, .rstn, .ce, .psel, .penable, .paddr, .pready, .pslverr,
	.host_mode, .local_loop_select, .remote_loop_select, .send_all_ones,
	.system_tx_clock, .recovered_rx_clock, .tx_timing_clock,
	.line_tx_pos, .line_tx_neg, .rx_clock_out);

// *** dv/lac_loop_tb.sv ***
// Self-checking bench for the loopback and all-ones block.
// Assumes the mapper model drives both the system and line streams.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
	end \
end
module testbench;
	logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic host_mode = 1'b0, local_loop_select = 1'b0, err;
	logic remote_loop_select = 1'b0, send_all_ones = 1'b0;
	logic sys_run = 1'b0, line_run = 1'b0;
	logic sys_pv = 1'b1, sys_nv = 1'b0;
	wire  pready, pslverr, system_tx_clock, tx_pos_data_in, tx_neg_data_in;
	wire  recovered_rx_clock, line_rx_pos, line_rx_neg, tx_timing_clock;
	wire  line_tx_pos, line_tx_neg, rx_clock_out;
	wire  rx_pos_data_out, rx_neg_data_out;
	wire  [31:0] prdata;
	int   checks, mismatches, cyc;
	// Four-state counters, so an unknown output cannot count as zero.
	integer ntx, nrx, nrxg, ntxn, ntxp;

	lac_loop_ctrl lac_loop_ctrl_inst (.core_clk, .rstn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.host_mode, .local_loop_select, .remote_loop_select,
		.send_all_ones, .system_tx_clock, .tx_pos_data_in,
		.tx_neg_data_in, .recovered_rx_clock, .line_rx_pos, .line_rx_neg,
		.tx_timing_clock, .line_tx_pos, .line_tx_neg, .rx_clock_out,
		.rx_pos_data_out, .rx_neg_data_out);
	lac_mapper_model #(.HALF(3)) lac_mapper_model_inst (.core_clk, .rstn,
		.run(sys_run), .pos_val(sys_pv), .neg_val(sys_nv),
		.bit_clk(system_tx_clock), .pos(tx_pos_data_in),
		.neg(tx_neg_data_in));
	lac_mapper_model #(.HALF(2)) lac_mapper_model_inst2 (.core_clk, .rstn,
		.run(line_run), .pos_val(1'b0), .neg_val(1'b1),
		.bit_clk(recovered_rx_clock), .pos(line_rx_pos), .neg(line_rx_neg));

	always #5 core_clk = ~core_clk;

	// ********************
	// Monitors and timeout
	// ********************
	always @(posedge core_clk) begin
		cyc++;
		ntx += tx_timing_clock;
		nrx += rx_clock_out;
		nrxg += rx_clock_out && rx_pos_data_out && !rx_neg_data_out;
		ntxn += tx_timing_clock && !line_tx_pos && line_tx_neg;
		ntxp += tx_timing_clock && line_tx_pos && !line_tx_neg;
		if (cyc == 5000) begin
			mismatches++;
			summarize;
		end
	end

	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic pins(input logic h, lo, re, ao);
		host_mode <= h;
		local_loop_select <= lo;
		remote_loop_select <= re;
		send_all_ones <= ao;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic go(input logic s, l, input int c);
		{ntx, nrx, nrxg, ntxn, ntxp} = '0;
		sys_run <= s;
		line_run <= l;
		repeat (c) @(posedge core_clk);
		sys_run <= 1'b0;
		line_run <= 1'b0;
		repeat (40) @(posedge core_clk);
	endtask

	task automatic t_regs;
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h00000018)
		apb(0, 12'h004, 0);
		`CHK(rd, 32'h00000001)
		apb(1, 12'h008, 32'hFFFFFFFF);
		`CHK(err, 1'b1)
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h0)
		apb(1, 12'h000, 32'hFFFFFFFF);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h0000007F)
		apb(1, 12'h000, 32'h18);
		ce <= 1'b0;
		repeat (2) @(posedge core_clk);
		ce <= 1'b1;
		@(posedge core_clk);
	endtask

	task automatic t_pin_modes;
		go(1, 1, 48);
		`CHK(ntx, 8)
		`CHK(nrx, 12)
		pins(0, 1, 1, 0);
		go(1, 1, 48);
		`CHK(ntx, 0)
		`CHK(nrxg, 8)
		`CHK(nrx, 8)
		pins(0, 1, 0, 0);
		go(1, 1, 48);
		`CHK(ntx, 8)
		`CHK(nrxg, 8)
		pins(0, 0, 1, 0);
		go(1, 1, 48);
		`CHK(ntxn, 12)
		`CHK(ntx, 12)
		`CHK(nrx, 12)
		pins(0, 0, 0, 1);
		sys_pv <= 1'b0;
		sys_nv <= 1'b1;
		go(1, 0, 48);
		`CHK(ntxp, 4)
		`CHK(ntxn, 4)
		sys_pv <= 1'b1;
		sys_nv <= 1'b0;
	endtask

	task automatic t_host;
		logic [31:0] wv [4] = '{32'h19, 32'h1B, 32'h1A, 32'h1C};
		logic [31:0] ev [4] = '{32'h02, 32'h04, 32'h08, 32'h11};
		pins(1, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			apb(1, 12'h000, wv[i]);
			apb(0, 12'h004, 0);
			`CHK(rd, ev[i])
		end
		// Remote loop with the attenuator on the receive side, 32 deep.
		apb(1, 12'h000, 32'h0A);
		go(0, 1, 96);
		`CHK(ntx > 0, 1'b1)
		`CHK(ntxn, ntx)
		`CHK(nrx, ntx)
		apb(1, 12'h000, 32'h22);
		go(0, 1, 96);
		`CHK(ntx > 0, 1'b1)
		`CHK(ntxn, ntx)
		apb(1, 12'h000, 32'h60);
		go(1, 0, 96);
		`CHK(ntxp > 0, 1'b1)
	endtask

	task summarize;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_pin_modes;
		t_host;
		summarize;
	end
endmodule // testbench

// *** dv/lac_mapper_model.sv ***
// Behavioural framer or mapper: one bit clock and two rails.
// Assumes core_clk is the bench clock; HALF sets the bit rate.
`timescale 1ns/1ps
module lac_mapper_model #(
	parameter HALF = 3
) (
	// Bench clock and control
	input  wire  core_clk,
	input  wire  rstn,
	input  wire  run,
	input  wire  pos_val,
	input  wire  neg_val,
	// Stream toward the block
	output logic bit_clk,
	output logic pos,
	output logic neg
);
	logic [3:0] cnt;

	// Between bursts the clock stands low and the rails toggle, so a
	// stale bit can never pass for a fresh one.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt     <= 4'h0;
			bit_clk <= 1'b0;
			pos     <= 1'b0;
			neg     <= 1'b0;
		end else if (run) begin
			cnt     <= (cnt == 2 * HALF - 1) ? 4'h0 : cnt + 4'h1;
			bit_clk <= (cnt >= HALF);
			pos     <= pos_val;
			neg     <= neg_val;
		end else begin
			cnt     <= 4'h0;
			bit_clk <= 1'b0;
			pos     <= ~pos;
			neg     <= ~neg;
		end
	end
endmodule // lac_mapper_model
